// ===== afrt_ctrl.v
/*
 * digital filter reset sequencing, conversion timing and output code clamp.
 * assumes register write strobes and command decode arrive as one-cycle pulses
 * from logic on core_clk_i; the run pin arrives asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "afrt_defines.vh"

// Contract
// - filter resets on writes, resync, run rise
// - resync: reset three clocks later, two long
// - input select write: three clock pulse
// - bias/mux/gain write: 32 modulator clocks
// - combined reset is AND of active-lows
// - resync/input write: short first conversion
// - other resets: longer first conversion
// - later conversions use steady period
// - results are 24-bit two's complement
// - results saturate at full scale
// - zero and one lsb code exactly
// - ready low with result buffer update
module afrt_ctrl #(
  parameter [31:0] FIRST_FAST = `AFRT_FIRST_FAST,
  parameter [31:0] FIRST_SLOW = `AFRT_FIRST_SLOW,
  parameter [31:0] STEADY     = `AFRT_STEADY,
  parameter [7:0]  MOD_DIV    = `AFRT_MOD_DIV
) (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire                   reset_cmd_i,
  input  wire                   wake_command_i,
  input  wire                   resync_cmd_i,
  input  wire                   input_select_reg_wr_i,
  input  wire                   bias_voltage_reg_wr_i,
  input  wire                   mux_ctrl_b_reg_wr_i,
  input  wire                   gain_rate_reg_wr_i,
  input  wire                   conv_run_i,
  input  wire [`AFRT_RAW_W-1:0] raw_result_i,
  output reg                    filter_reset_n_o,
  output reg                    result_ready_n_o,
  output reg  [23:0]            result_o
);

  // ----------------------------------------------------------------
  // run pin synchroniser
  // ----------------------------------------------------------------
  // an edge counts once stages two and three agree, so a glitch shorter
  // than one clock never resets the filter.
  // stages and level start high: a pin that is already high at release is
  // not a fresh rise, and the reset itself already picks the long first
  // count. limitation: a rise that happens during reset is not an edge.
  reg [2:0] run_sync;
  reg       run_level;
  wire      run_agree;
  wire      run_rise;
  assign run_agree = (run_sync[1] == run_sync[2]);
  assign run_rise  = run_agree && run_sync[2] && !run_level;

  always @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      run_sync  <= 3'h7;
      run_level <= 1'b1;
    end
    else
    begin
      run_sync <= {run_sync[1:0], conv_run_i};
      if (run_agree)
        run_level <= run_sync[2];
    end

  // ----------------------------------------------------------------
  // individual reset pulses
  // ----------------------------------------------------------------
  reg [3:0] sync_dly;
  reg [3:0] sync_cnt;
  reg [3:0] mux_cnt;
  reg [7:0] mod_pre;
  reg [7:0] mod_cnt;
  wire slow_evt = bias_voltage_reg_wr_i | mux_ctrl_b_reg_wr_i | gain_rate_reg_wr_i
                  | run_rise | reset_cmd_i | wake_command_i;
  wire fast_evt = resync_cmd_i | input_select_reg_wr_i;

  always @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      sync_dly <= 4'h0;
      sync_cnt <= 4'h0;
      mux_cnt  <= 4'h0;
      mod_pre  <= 8'h0;
      mod_cnt  <= 8'h0;
    end
    else
    begin
      // resync delay then two-clock pulse
      if (resync_cmd_i)
        sync_dly <= `AFRT_SYNC_DELAY;
      else if (sync_dly != 4'h0)
        sync_dly <= sync_dly - 4'h1;
      if (sync_dly == 4'h1)
        sync_cnt <= `AFRT_SHORT_PULSE;
      else if (sync_cnt != 4'h0)
        sync_cnt <= sync_cnt - 4'h1;
      // rewrite of the same value still resets
      if (input_select_reg_wr_i)
        mux_cnt <= `AFRT_SHORT_PULSE;
      else if (mux_cnt != 4'h0)
        mux_cnt <= mux_cnt - 4'h1;
      // modulator clock pulse counted from a prescaler
      if (slow_evt)
      begin
        mod_cnt <= `AFRT_MOD_PULSE;
        mod_pre <= 8'h0;
      end
      else if (mod_cnt != 8'h0)
      begin
        if (mod_pre == MOD_DIV - 8'h1)
        begin
          mod_pre <= 8'h0;
          mod_cnt <= mod_cnt - 8'h1;
        end
        else
          mod_pre <= mod_pre + 8'h1;
      end
    end

  // ----------------------------------------------------------------
  // combined filter reset
  // ----------------------------------------------------------------
  // one active-low term per pulse counter; all strobes but resync pull reset low at once,
  // so a back-to-back write leaves no one-cycle gap before its count loads
  wire sync_pulse_n = (sync_cnt == 4'h0);
  wire mux_pulse_n  = (mux_cnt == 4'h0) & !input_select_reg_wr_i;
  wire mod_pulse_n  = (mod_cnt == 8'h0) & !slow_evt;
  wire next_filter_reset_n = sync_pulse_n & mux_pulse_n & mod_pulse_n;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  reg        slow_src;
  reg        first_conv;
  reg [31:0] conv_cnt;
  reg  [31:0] conv_len;
  wire        conv_done;

  // length of the conversion now running
  always @*
  begin
    conv_len = STEADY;
    case ({first_conv, slow_src})
      2'b10:   conv_len = FIRST_FAST;
      2'b11:   conv_len = FIRST_SLOW;
      default: conv_len = STEADY;
    endcase
  end

  assign conv_done = filter_reset_n_o && (conv_cnt == conv_len - 32'h1);

  // ----------------------------------------------------------------
  // output code
  // ----------------------------------------------------------------
  // clamp of the wider filter output
  wire [`AFRT_RAW_W-1:0] raw = raw_result_i;
  wire raw_hi = !raw[`AFRT_RAW_W-1] && (raw[`AFRT_RAW_W-2:23] != 2'h0);
  wire raw_lo = raw[`AFRT_RAW_W-1] && (raw[`AFRT_RAW_W-2:23] != 2'h3);
  wire [23:0] next_result = raw_hi ? `AFRT_CODE_MAX :
                            raw_lo ? `AFRT_CODE_MIN : raw[23:0];

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // counting waits for the registered release, so the first result lands
  // exactly the chosen length after filter_reset_n_o goes high
  always @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
    begin
      filter_reset_n_o <= 1'b0;
      slow_src         <= 1'b1;
      first_conv       <= 1'b1;
      conv_cnt         <= 32'h0;
      result_ready_n_o <= 1'b1;
      result_o         <= 24'h0;
    end
    else
    begin
      filter_reset_n_o <= next_filter_reset_n;
      // latest source picks the first conversion length
      if (slow_evt)
        slow_src <= 1'b1;
      else if (fast_evt)
        slow_src <= 1'b0;
      if (!next_filter_reset_n)
      begin
        // restart from zero on release
        conv_cnt         <= 32'h0;
        first_conv       <= 1'b1;
        result_ready_n_o <= 1'b1;
      end
      else if (conv_done)
      begin
        conv_cnt         <= 32'h0;
        first_conv       <= 1'b0;
        result_ready_n_o <= 1'b0;
        result_o         <= next_result;
      end
      else if (filter_reset_n_o)
      begin
        conv_cnt         <= conv_cnt + 32'h1;
        result_ready_n_o <= 1'b1;
      end
    end

endmodule
`default_nettype wire

// ===== afrt_ctrl_assertions.sv
/* port checker for afrt_ctrl; assumes MOD_DIV >= 1 and strobes low while reset */
`timescale 1ns/1ps
`default_nettype none
module afrt_ctrl_assertions (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        resync_cmd_i,
  input wire logic        input_select_reg_wr_i,
  input wire logic        bias_voltage_reg_wr_i,
  input wire logic        mux_ctrl_b_reg_wr_i,
  input wire logic        gain_rate_reg_wr_i,
  input wire logic        filter_reset_n_o,
  input wire logic        result_ready_n_o,
  input wire logic [23:0] result_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire slow = bias_voltage_reg_wr_i | mux_ctrl_b_reg_wr_i | gain_rate_reg_wr_i;
  chk_sel_pulse: assert property (input_select_reg_wr_i |=> !filter_reset_n_o [*3])
    else $error("select write pulse short");
  chk_sync_delay: assert property (resync_cmd_i |-> ##4 !filter_reset_n_o [*2])
    else $error("resync pulse misplaced");
  // only cycle 33, the last low cycle when MOD_DIV is one, is checked, so any MOD_DIV of one or more fits
  chk_slow_pulse: assert property (slow |-> ##33 !filter_reset_n_o)
    else $error("slow write pulse short");
  chk_and_hold: assert property ($rose(filter_reset_n_o) |-> !$past(slow | input_select_reg_wr_i))
    else $error("reset released under new strobe");
  chk_ready_one: assert property (!result_ready_n_o |=> result_ready_n_o)
    else $error("ready low too long");
  chk_ready_quiet: assert property (!filter_reset_n_o |-> result_ready_n_o)
    else $error("ready during filter reset");
  chk_result_load: assert property ($changed(result_o) |-> !result_ready_n_o)
    else $error("result moved without ready");
  chk_ready_settle: assert property (!result_ready_n_o |-> $past(filter_reset_n_o, 8))
    else $error("ready too soon after reset");
endmodule
bind afrt_ctrl afrt_ctrl_assertions u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .resync_cmd_i(resync_cmd_i), .input_select_reg_wr_i(input_select_reg_wr_i),
  .bias_voltage_reg_wr_i(bias_voltage_reg_wr_i), .mux_ctrl_b_reg_wr_i(mux_ctrl_b_reg_wr_i),
  .gain_rate_reg_wr_i(gain_rate_reg_wr_i), .filter_reset_n_o(filter_reset_n_o),
  .result_ready_n_o(result_ready_n_o), .result_o(result_o));
`default_nettype wire

// ===== afrt_defines.vh
/*
 * constants for the filter reset and conversion timing block.
 * assumes a 4.096 mhz system clock derived conversion counts; included by afrt_ctrl.v.
 */
`ifndef AFRT_DEFINES_VH
`define AFRT_DEFINES_VH

// ----------------------------------------------------------------
// reset pulse timing
// ----------------------------------------------------------------
`define AFRT_SYNC_DELAY      4'h2
`define AFRT_SHORT_PULSE     4'h2
`define AFRT_MOD_PULSE       8'h20
`define AFRT_MOD_DIV         8'h10

// ----------------------------------------------------------------
// data format
// ----------------------------------------------------------------
`define AFRT_CODE_MAX        24'h7fffff
`define AFRT_CODE_MIN        24'h800000
`define AFRT_RAW_W           26

// ----------------------------------------------------------------
// conversion counts at 2000 sps, defaults only
// ----------------------------------------------------------------
`define AFRT_FIRST_FAST      32'h0000083c
`define AFRT_FIRST_SLOW      32'h00000942
`define AFRT_STEADY          32'h00000800

`endif

// ===== afrt_host.sv
/* host model: command and write strobes, run pin, raw filter data; shares the core clock */
`timescale 1ns/1ps
`default_nettype none
module afrt_host (
  input  wire logic        core_clk_i,
  output var  logic [6:0]  strobe_o,
  output var  logic        conv_run_o,
  output var  logic [25:0] raw_o
);
  initial strobe_o = 7'h00;
  initial conv_run_o = 1'b1;
  initial raw_o = 26'h0;
  task automatic set_raw(input logic [25:0] v);
    @(posedge core_clk_i);
    raw_o <= v;
  endtask
  // run pin drops four cycles then rises, the rise being what resets
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    if (k == 7) conv_run_o <= 1'b0;
    else strobe_o[k] <= 1'b1;
    if (k == 7) repeat (3) @(posedge core_clk_i);
    @(posedge core_clk_i);
    strobe_o <= 7'h00;
    conv_run_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb_adc_filter_reset_timing.sv
/* bench for afrt_ctrl with short counts; host model drives every input but clock and reset */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_filter_reset_timing;
  localparam logic [31:0] FF = 32'h14, FS = 32'h1e, ST = 32'h10;
  logic core_clk_i = 1'b0, rst_i = 1'b1, run, frn, rdy_n;
  logic [6:0] stb;
  logic [25:0] raw;
  logic [23:0] res;
  logic [31:0] s = 32'hc;
  int n_fail = 0, comparisons = 0, cyc = 0, tf, ts, t, i;
  logic [25:0] corner [7] = '{26'h0, 26'h1, 26'h3ffffff, 26'h7fffff, 26'h800000,
                              26'h3800000, 26'h37fffff};
  always #10 core_clk_i = ~core_clk_i;
  afrt_host host (.core_clk_i(core_clk_i), .strobe_o(stb), .conv_run_o(run), .raw_o(raw));
  afrt_ctrl #(.FIRST_FAST(FF), .FIRST_SLOW(FS), .STEADY(ST), .MOD_DIV(8'h01)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reset_cmd_i(stb[0]), .wake_command_i(stb[1]),
    .resync_cmd_i(stb[2]), .input_select_reg_wr_i(stb[3]), .bias_voltage_reg_wr_i(stb[4]),
    .mux_ctrl_b_reg_wr_i(stb[5]), .gain_rate_reg_wr_i(stb[6]), .conv_run_i(run),
    .raw_result_i(raw), .filter_reset_n_o(frn), .result_ready_n_o(rdy_n), .result_o(res));
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [23:0] clamp(input logic [25:0] r);
    if (!r[25] && r[24:23] != 2'h0) return 24'h7fffff;
    if (r[25] && r[24:23] != 2'h3) return 24'h800000;
    return r[23:0];
  endfunction
  task automatic results;
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_time(input string n, input int e, input int g);
    comparisons++;
    if (e != g) begin n_fail++; $display("mismatch %s exp %0d got %0d", n, e, g); end
  endtask
  task automatic chk_code(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (e !== g) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end
  endtask
  // sampling on the falling edge keeps clear of the outputs' update edge
  task automatic wait_rdy(output int n);
    n = 0;
    do begin @(negedge core_clk_i); n++; end while (rdy_n !== 1'b0 && n < 99);
  endtask
  task automatic run_one(input int k, output int n);
    host.pulse(k);
    repeat (60) if (frn !== 1'b0) @(negedge core_clk_i);
    repeat (60) if (frn !== 1'b1) @(negedge core_clk_i);
    wait_rdy(n);
  endtask
  always @(posedge core_clk_i) if (++cyc == 8000) begin n_fail++; results; end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 12; i++) begin
      host.set_raw(i < 7 ? corner[i] : xs() >> 6);
      run_one(2, tf);
      chk_code("result", clamp(raw), res);
      run_one(6, ts);
      chk_time("first_gap", FS - FF, ts - tf);
      wait_rdy(t);
      chk_time("steady", ST, t);
    end
    for (i = 0; i < 8; i++) begin
      run_one(i, t);
      chk_time("first_len", (i == 2 || i == 3) ? tf : ts, t);
    end
    results;
  end
endmodule
`default_nettype wire
